// ===== core/ismp_defines.vh
// constants for the coefficient-only macroblock payload unpacker
`ifndef ISMP_DEFINES_VH
`define ISMP_DEFINES_VH

// ---------------------------------------------------------------
// command dword positions
// ---------------------------------------------------------------
`define ISMP_DW_FIRST_INLINE 4'h4
`define ISMP_DW_HDR_LAST 4'h3
`define ISMP_DW_LAST_INLINE 4'hd
`define ISMP_DW_MAX 4'hf

// ---------------------------------------------------------------
// payload layout: ten inline dwords padded to two 8-dword registers
// ---------------------------------------------------------------
`define ISMP_PAY_INLINE_LAST 4'h9
`define ISMP_PAY_LAST 4'hf
`define ISMP_PAY_PAD_DATA 32'h0000_0000

// ---------------------------------------------------------------
// fields of the first inline dword
// ---------------------------------------------------------------
`define ISMP_VFS_MSB 31
`define ISMP_VFS_LSB 28
`define ISMP_SECOND_FIELD_BIT 27
`define ISMP_MOTION_MSB 25
`define ISMP_MOTION_LSB 24

// raw motion kind codes
`define ISMP_MK_RESERVED 2'h0
`define ISMP_MK_FIELD 2'h1
`define ISMP_MK_FRAME_OR_16X8 2'h2
`define ISMP_MK_DUAL_PRIME 2'h3

// decoded prediction kinds
`define ISMP_PRED_RESERVED 3'h0
`define ISMP_PRED_FIELD 3'h1
`define ISMP_PRED_FRAME 3'h2
`define ISMP_PRED_16X8 3'h3
`define ISMP_PRED_DUAL_PRIME 3'h4

// picture structure value that marks a frame destination
`define ISMP_PIC_FRAME 2'h3

// ---------------------------------------------------------------
// register map
// ---------------------------------------------------------------
`define ISMP_ADDR_CTRL 8'h00
`define ISMP_ADDR_STATUS 8'h04
`define ISMP_ADDR_LAST_DW0 8'h08
`define ISMP_ADDR_JOBS 8'h0c
`define ISMP_CTRL_MODE_BIT 0
`define ISMP_CTRL_PIC_LSB 1
`define ISMP_CTRL_PIC_MSB 2
`define ISMP_CTRL_RESET 3'h0
`define ISMP_ZERO32 32'h0000_0000
`define ISMP_ZERO16 16'h0000
`define ISMP_ONE16 16'h0001
`define ISMP_ONE4 4'h1

`endif

// ===== core/ismp_field_decode.v
// decoder for the consumed fields of the first inline dword
`timescale 1ns/1ps
`include "ismp_defines.vh"

module ismp_field_decode (
   input wire [31:0] dword0,
   input wire [1:0] picture_structure,
   output wire [3:0] vertical_field_select_bits,
   output wire second_field_flag,
   output reg [2:0] pred_kind,
   output wire motion_reserved
);
   wire [1:0] motion_kind_field;
   wire frame_dest;

   // bit 28 is r0 s0 up to bit 31 r1 s1; 0 = top field, 1 = bottom
   assign vertical_field_select_bits = dword0[`ISMP_VFS_MSB:`ISMP_VFS_LSB];
   assign second_field_flag = dword0[`ISMP_SECOND_FIELD_BIT];
   assign motion_kind_field = dword0[`ISMP_MOTION_MSB:`ISMP_MOTION_LSB];
   assign frame_dest = (picture_structure == `ISMP_PIC_FRAME);
   // flagged, never relied on
   assign motion_reserved = (motion_kind_field == `ISMP_MK_RESERVED);

   always @* begin
      case (motion_kind_field)
         `ISMP_MK_FIELD: pred_kind = `ISMP_PRED_FIELD;
         `ISMP_MK_FRAME_OR_16X8: pred_kind = frame_dest ? `ISMP_PRED_FRAME : `ISMP_PRED_16X8;
         `ISMP_MK_DUAL_PRIME: pred_kind = `ISMP_PRED_DUAL_PRIME;
         default: pred_kind = `ISMP_PRED_RESERVED;
      endcase
   end
endmodule // ismp_field_decode

// ===== core/ismp_payload.v
// coefficient-only mode macroblock inline payload unpacker
//
// The placing of the registers and strobed register access were left to the implementer.
`timescale 1ns/1ps
`include "ismp_defines.vh"

module ismp_payload (
   input wire clk,
   input wire reset_n,
   input wire in_valid,
   input wire in_sop,
   input wire [31:0] in_data,
   output reg in_ready,
   output reg pay_valid,
   output reg pay_first,
   output reg pay_last,
   output reg [31:0] pay_data,
   output reg mb_done,
   output reg [3:0] mb_field_select,
   output reg mb_second_field,
   output reg [2:0] mb_pred_kind,
   output reg mb_motion_reserved,
   input wire [7:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_write,
   input wire reg_read,
   output reg [31:0] reg_rdata
);
   // ---------------------------------------------------------------
   // states
   // ---------------------------------------------------------------
   localparam [2:0] st_idle = 3'h0;
   localparam [2:0] st_hdr = 3'h1;
   localparam [2:0] st_inline = 3'h2;
   localparam [2:0] st_pad = 3'h3;
   localparam [2:0] st_skip = 3'h4;

   // ---------------------------------------------------------------
   // reset release
   // ---------------------------------------------------------------
   reg rst_meta;
   reg rst_sync_n;

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_meta <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_sync_n <= rst_meta;
      end
   end

   // ---------------------------------------------------------------
   // declarations
   // ---------------------------------------------------------------
   reg [2:0] state;
   reg [2:0] next_state;
   reg [3:0] cmd_idx;
   reg [3:0] next_cmd_idx;
   reg [3:0] pay_idx;
   reg [3:0] next_pay_idx;
   reg coefficient_only_mode;
   reg [1:0] picture_structure;
   reg [31:0] last_dw0;
   reg [15:0] job_count;
   reg [15:0] skip_count;
   reg truncated;
   reg emit;
   reg [31:0] emit_data;
   reg emit_first;
   reg emit_last;
   reg done_now;
   reg capture_dw0;

   wire accept;
   wire [3:0] dec_vfs;
   wire dec_second;
   wire [2:0] dec_kind;
   wire dec_reserved;

   assign accept = in_valid & in_ready;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function [3:0] ismp_inc4;
      input [3:0] v;
      begin
         ismp_inc4 = (v == `ISMP_DW_MAX) ? v : v + `ISMP_ONE4;
      end
   endfunction

   function [15:0] ismp_inc16;
      input [15:0] v;
      begin
         ismp_inc16 = v + `ISMP_ONE16;
      end
   endfunction

   // ---------------------------------------------------------------
   // field decode of the first inline dword as it arrives
   // ---------------------------------------------------------------
   ismp_field_decode u_decode (
      .dword0(in_data),
      .picture_structure(picture_structure),
      .vertical_field_select_bits(dec_vfs),
      .second_field_flag(dec_second),
      .pred_kind(dec_kind),
      .motion_reserved(dec_reserved)
   );

   // ---------------------------------------------------------------
   // command parser
   // ---------------------------------------------------------------
   always @* begin
      next_state = state;
      next_cmd_idx = cmd_idx;
      next_pay_idx = pay_idx;
      emit = 1'b0;
      emit_data = `ISMP_PAY_PAD_DATA;
      emit_first = 1'b0;
      emit_last = 1'b0;
      done_now = 1'b0;
      capture_dw0 = 1'b0;
      if (accept && in_sop) begin
         // a new command always restarts the parse; with the mode off it goes to st_skip and no job starts
         next_cmd_idx = `ISMP_ONE4;
         next_pay_idx = 4'h0;
         next_state = coefficient_only_mode ? st_hdr : st_skip;
      end else begin
         case (state)
            st_hdr: begin
               if (accept) begin
                  next_cmd_idx = ismp_inc4(cmd_idx);
                  if (cmd_idx == `ISMP_DW_HDR_LAST) begin
                     next_state = st_inline;
                  end
               end
            end
            st_inline: begin
               if (accept) begin
                  // whole dword passes, reserved bit 26 included
                  emit = 1'b1;
                  emit_data = in_data;
                  emit_first = (cmd_idx == `ISMP_DW_FIRST_INLINE);
                  capture_dw0 = (cmd_idx == `ISMP_DW_FIRST_INLINE);
                  next_cmd_idx = ismp_inc4(cmd_idx);
                  next_pay_idx = ismp_inc4(pay_idx);
                  if (cmd_idx == `ISMP_DW_LAST_INLINE) begin
                     next_state = st_pad;
                  end
               end
            end
            st_pad: begin
               emit = 1'b1;
               emit_data = `ISMP_PAY_PAD_DATA;
               next_pay_idx = ismp_inc4(pay_idx);
               if (pay_idx == `ISMP_PAY_LAST) begin
                  emit_last = 1'b1;
                  done_now = 1'b1;
                  next_state = st_skip;
               end
            end
            st_skip: begin
               // trailing dwords of the command are not inline data
               if (accept) begin
                  next_cmd_idx = ismp_inc4(cmd_idx);
               end
            end
            default: begin
               next_state = st_idle;
            end
         endcase
      end
   end

   always @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         state <= st_idle;
         cmd_idx <= 4'h0;
         pay_idx <= 4'h0;
         in_ready <= 1'b0;
      end else begin
         state <= next_state;
         cmd_idx <= next_cmd_idx;
         pay_idx <= next_pay_idx;
         // input stalls while padding so the payload stays in order
         in_ready <= (next_state != st_pad);
      end
   end

   // ---------------------------------------------------------------
   // payload output
   // ---------------------------------------------------------------
   always @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         pay_valid <= 1'b0;
         pay_first <= 1'b0;
         pay_last <= 1'b0;
         pay_data <= `ISMP_ZERO32;
      end else begin
         pay_valid <= emit;
         pay_first <= emit_first;
         pay_last <= emit_last;
         pay_data <= emit ? emit_data : `ISMP_ZERO32;
      end
   end

   // ---------------------------------------------------------------
   // consumed fields, captured at the first inline dword; mb outputs held until the next job finishes
   // ---------------------------------------------------------------
   reg [3:0] hold_vfs;
   reg hold_second;
   reg [2:0] hold_kind;
   reg hold_reserved;

   always @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         hold_vfs <= 4'h0;
         hold_second <= 1'b0;
         hold_kind <= `ISMP_PRED_RESERVED;
         hold_reserved <= 1'b0;
         last_dw0 <= `ISMP_ZERO32;
      end else if (capture_dw0) begin
         hold_vfs <= dec_vfs;
         // issuer keeps this zero for non-field pictures
         hold_second <= dec_second;
         hold_kind <= dec_kind;
         hold_reserved <= dec_reserved;
         last_dw0 <= in_data;
      end
   end

   always @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         mb_done <= 1'b0;
         mb_field_select <= 4'h0;
         mb_second_field <= 1'b0;
         mb_pred_kind <= `ISMP_PRED_RESERVED;
         mb_motion_reserved <= 1'b0;
      end else begin
         mb_done <= done_now;
         if (done_now) begin
            mb_field_select <= hold_vfs;
            mb_second_field <= hold_second;
            mb_pred_kind <= hold_kind;
            mb_motion_reserved <= hold_reserved;
         end
      end
   end

   // ---------------------------------------------------------------
   // job accounting
   // ---------------------------------------------------------------
   wire sop_in_inline;
   wire status_clear;

   // a command that ends early, in its header or inline dwords, leaves its job without its last dword
   assign sop_in_inline = accept && in_sop && ((state == st_inline) || (state == st_hdr));
   assign status_clear = reg_write && (reg_addr == `ISMP_ADDR_STATUS);

   always @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         job_count <= `ISMP_ZERO16;
         skip_count <= `ISMP_ZERO16;
         truncated <= 1'b0;
      end else begin
         if (done_now) begin
            job_count <= ismp_inc16(job_count);
         end
         if (accept && in_sop && !coefficient_only_mode) begin
            skip_count <= ismp_inc16(skip_count);
         end
         // set wins over a clear in the same cycle
         if (sop_in_inline) begin
            truncated <= 1'b1;
         end else if (status_clear && reg_wdata[0]) begin
            truncated <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // register port
   // ---------------------------------------------------------------
   always @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         // mode off after reset, so no job starts before software sets it up
         {picture_structure, coefficient_only_mode} <= `ISMP_CTRL_RESET;
      end else if (reg_write && (reg_addr == `ISMP_ADDR_CTRL)) begin
         coefficient_only_mode <= reg_wdata[`ISMP_CTRL_MODE_BIT];
         picture_structure <= reg_wdata[`ISMP_CTRL_PIC_MSB:`ISMP_CTRL_PIC_LSB];
      end
   end

   always @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         reg_rdata <= `ISMP_ZERO32;
      end else if (reg_read) begin
         if (reg_addr == `ISMP_ADDR_CTRL) begin
            reg_rdata <= {29'h0000_0000, picture_structure, coefficient_only_mode};
         end else if (reg_addr == `ISMP_ADDR_STATUS) begin
            reg_rdata <= {7'h00, hold_vfs, hold_second, hold_kind,
                          5'h00, hold_reserved, state, in_ready, 6'h00, truncated};
         end else if (reg_addr == `ISMP_ADDR_LAST_DW0) begin
            reg_rdata <= last_dw0;
         end else if (reg_addr == `ISMP_ADDR_JOBS) begin
            reg_rdata <= {skip_count, job_count};
         end else begin
            reg_rdata <= `ISMP_ZERO32;
         end
      end else begin
         // data stand for one cycle only
         reg_rdata <= `ISMP_ZERO32;
      end
   end
endmodule // ismp_payload

// ===== verif/ismp_payload_properties.sv
// port-level assertions for the payload unpacker
`timescale 1ns/1ps
`include "ismp_defines.vh"
module ismp_payload_checker (
   input wire clk,
   input wire reset_n,
   input wire in_valid,
   input wire in_sop,
   input wire [31:0] in_data,
   input wire in_ready,
   input wire pay_valid,
   input wire pay_first,
   input wire pay_last,
   input wire [31:0] pay_data,
   input wire mb_done,
   input wire [3:0] mb_field_select,
   input wire mb_second_field,
   input wire [2:0] mb_pred_kind,
   input wire mb_motion_reserved,
   input wire [7:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_write,
   input wire reg_read,
   input wire [31:0] reg_rdata
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   // ---
   // shadow of mode and dword position
   // ---
   reg [3:0] cnt;
   reg mode;
   reg act;
   reg [1:0] pic;
   reg [1:0] cpic;
   reg [31:0] cap;
   wire inl = in_valid && in_ready && !in_sop && act;
   wire [1:0] mk = cap[25:24];
   wire [2:0] ek = (mk == `ISMP_MK_RESERVED) ? `ISMP_PRED_RESERVED :
      (mk == `ISMP_MK_FIELD) ? `ISMP_PRED_FIELD :
      (mk == `ISMP_MK_DUAL_PRIME) ? `ISMP_PRED_DUAL_PRIME :
      (cpic == `ISMP_PIC_FRAME) ? `ISMP_PRED_FRAME : `ISMP_PRED_16X8;
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt <= 4'h0;
         mode <= 1'b0;
         act <= 1'b0;
         pic <= 2'h0;
         cpic <= 2'h0;
         cap <= 32'h0;
      end else begin
         if (reg_write && reg_addr == `ISMP_ADDR_CTRL) begin
            mode <= reg_wdata[0];
            pic <= reg_wdata[2:1];
         end
         if (in_valid && in_ready && in_sop) begin
            cnt <= 4'h1;
            act <= mode;
         end else if (in_valid && in_ready && cnt != 4'he) begin
            cnt <= cnt + 4'h1;
         end
         if (inl && cnt == 4'h4) begin
            cap <= in_data;
            cpic <= pic;
         end
      end
   end
   property p_fwd;
      inl && cnt >= 4'h4 && cnt <= 4'hd |=> pay_valid && pay_data == $past(in_data);
   endproperty
   a_fwd: assert property (p_fwd) else $error("inline dword not forwarded");
   property p_first;
      inl && cnt == 4'h4 |=> pay_valid && pay_first;
   endproperty
   a_first: assert property (p_first) else $error("first payload not marked");
   property p_pad;
      inl && cnt == 4'hd |=> ##1 (pay_valid && pay_data == 32'h0 && !pay_last) [*5]
         ##1 (pay_valid && pay_last && mb_done && pay_data == 32'h0);
   endproperty
   a_pad: assert property (p_pad) else $error("padding wrong");
   property p_ready;
      inl && cnt == 4'hd |=> (!in_ready) [*6] ##1 in_ready;
   endproperty
   a_ready: assert property (p_ready) else $error("ready wrong around padding");
   property p_done;
      mb_done |-> pay_valid && pay_last && $past(pay_valid, 6);
   endproperty
   a_done: assert property (p_done) else $error("job end wrong");
   property p_vfs;
      mb_done |-> mb_field_select == cap[31:28];
   endproperty
   a_vfs: assert property (p_vfs) else $error("field select wrong");
   property p_second;
      mb_done |-> mb_second_field == cap[27];
   endproperty
   a_second: assert property (p_second) else $error("second field wrong");
   property p_kind;
      mb_done |-> mb_pred_kind == ek;
   endproperty
   a_kind: assert property (p_kind) else $error("prediction kind wrong");
   property p_rsv;
      mb_done |-> mb_motion_reserved == (mk == `ISMP_MK_RESERVED);
   endproperty
   a_rsv: assert property (p_rsv) else $error("reserved flag wrong");
   c_dual: cover property (mb_done && mb_pred_kind == `ISMP_PRED_DUAL_PRIME);
   c_16x8: cover property (mb_done && mb_pred_kind == `ISMP_PRED_16X8);
   c_read: cover property (reg_read ##1 reg_rdata != 32'h0);
endmodule // ismp_payload_checker
bind ismp_payload ismp_payload_checker i_chk (.clk(clk), .reset_n(reset_n),
   .in_valid(in_valid), .in_sop(in_sop), .in_data(in_data), .in_ready(in_ready),
   .pay_valid(pay_valid), .pay_first(pay_first), .pay_last(pay_last), .pay_data(pay_data),
   .mb_done(mb_done), .mb_field_select(mb_field_select), .mb_second_field(mb_second_field),
   .mb_pred_kind(mb_pred_kind), .mb_motion_reserved(mb_motion_reserved),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
   .reg_read(reg_read), .reg_rdata(reg_rdata));

// ===== verif/ismp_cmd_source.sv
// upstream command source model, one work command per start
`timescale 1ns/1ps
module ismp_cmd_source (
   input wire clk,
   input wire reset_n,
   input wire start,
   input wire slow,
   input wire [31:0] p0,
   input wire in_ready,
   output reg in_valid,
   output reg in_sop,
   output reg [31:0] in_data,
   output reg done
);
   reg [3:0] k;
   reg busy;
   // header words are arbitrary; parameters go inline from dword 4
   function [31:0] word(input [3:0] i);
      word = (i < 4'h4) ? {28'hc0de000, i} : p0 + {28'h0, i - 4'h4} * 32'h0101_0101;
   endfunction
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         in_valid <= 1'b0;
         in_sop <= 1'b0;
         in_data <= 32'h0;
         done <= 1'b0;
         busy <= 1'b0;
         k <= 4'h0;
      end else begin
         done <= 1'b0;
         if (start) begin
            busy <= 1'b1;
            k <= 4'h0;
         end else if (in_valid && in_ready) begin
            k <= k + 4'h1;
            busy <= (k != 4'hd);
            done <= (k == 4'hd);
            in_valid <= !slow && k != 4'hd;
            in_sop <= 1'b0;
            // released data never keeps the last value
            in_data <= (slow || k == 4'hd) ? ~in_data : word(k + 4'h1);
         end else if (busy && !in_valid) begin
            in_valid <= 1'b1;
            in_sop <= (k == 4'h0);
            in_data <= word(k);
         end else if (!in_valid) begin
            in_data <= ~in_data;
         end
      end
   end
endmodule // ismp_cmd_source

// ===== verif/ismp_payload_tb.sv
// self-checking bench for the payload unpacker
`timescale 1ns/1ps
`include "ismp_defines.vh"
module ismp_payload_tb;
   reg clk = 1'b0;
   reg reset_n = 1'b0;
   reg start = 1'b0;
   reg slow = 1'b0;
   reg [31:0] p0 = 32'h0;
   reg [7:0] reg_addr = 8'h0;
   reg [31:0] reg_wdata = 32'h0;
   reg reg_write = 1'b0;
   reg reg_read = 1'b0;
   wire in_valid, in_sop, in_ready, pay_valid, pay_first, pay_last, mb_done, src_done;
   wire mb_second_field, mb_motion_reserved;
   wire [31:0] in_data, pay_data, reg_rdata;
   wire [3:0] mb_field_select;
   wire [2:0] mb_pred_kind;
   reg [3:0] pidx = 4'h0;
   reg [1:0] pic;
   reg [31:0] d;
   integer failures = 0;
   integer n_checks = 0;
   integer n_pay = 0;
   integer i;
   integer t;
   always #5 clk = ~clk;
   ismp_payload i_ismp_payload (.clk(clk), .reset_n(reset_n), .in_valid(in_valid),
      .in_sop(in_sop), .in_data(in_data), .in_ready(in_ready), .pay_valid(pay_valid),
      .pay_first(pay_first), .pay_last(pay_last), .pay_data(pay_data), .mb_done(mb_done),
      .mb_field_select(mb_field_select), .mb_second_field(mb_second_field),
      .mb_pred_kind(mb_pred_kind), .mb_motion_reserved(mb_motion_reserved),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
      .reg_read(reg_read), .reg_rdata(reg_rdata));
   ismp_cmd_source i_ismp_cmd_source (.clk(clk), .reset_n(reset_n), .start(start),
      .slow(slow), .p0(p0), .in_ready(in_ready), .in_valid(in_valid), .in_sop(in_sop),
      .in_data(in_data), .done(src_done));
   task chk(input [31:0] got, input [31:0] exp);
      begin
         n_checks = n_checks + 1;
         if (got !== exp) begin
            failures = failures + 1;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
         end
      end
   endtask
   task report_and_stop;
      begin
         $display("checks %0d mismatches %0d", n_checks, failures);
         if (failures == 0 && n_checks > 0)
            $display("Simulation passed");
         else
            $display("Simulation failed");
         $finish;
      end
   endtask
   task wr(input [7:0] a, input [31:0] v);
      begin
         reg_addr <= a;
         reg_wdata <= v;
         reg_write <= 1'b1;
         @(posedge clk);
         reg_write <= 1'b0;
         @(posedge clk);
      end
   endtask
   task rdc(input [7:0] a, input [31:0] exp);
      begin
         reg_addr <= a;
         reg_read <= 1'b1;
         @(posedge clk);
         reg_read <= 1'b0;
         @(posedge clk);
         chk(reg_rdata, exp);
      end
   endtask
   // returns in the cycle that ends the job, so job outputs can be read
   task run(input [31:0] v, input s, input job);
      begin
         p0 <= v;
         slow <= s;
         start <= 1'b1;
         @(posedge clk);
         start <= 1'b0;
         t = 0;
         while (!(job ? mb_done : src_done) && t < 200) begin
            @(posedge clk);
            t = t + 1;
         end
         if (t == 200) begin
            failures = failures + 1;
            report_and_stop;
         end
      end
   endtask
   function [2:0] ekind(input [1:0] m, input [1:0] p);
      ekind = (m == 2'h0) ? `ISMP_PRED_RESERVED : (m == 2'h1) ? `ISMP_PRED_FIELD :
         (m == 2'h3) ? `ISMP_PRED_DUAL_PRIME : (p == 2'h3) ? `ISMP_PRED_FRAME : `ISMP_PRED_16X8;
   endfunction
   always @(posedge clk) begin
      if (pay_valid) begin
         chk(pay_data, (pidx < 4'ha) ? p0 + {28'h0, pidx} * 32'h0101_0101 : 32'h0);
         chk({pay_first, pay_last, mb_done}, {pidx == 4'h0, pidx == 4'hf, pidx == 4'hf});
         pidx <= pidx + 4'h1;
         n_pay = n_pay + 1;
      end
   end
   initial begin
      repeat (4) @(posedge clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge clk);
      rdc(`ISMP_ADDR_CTRL, 32'h0);
      rdc(`ISMP_ADDR_JOBS, 32'h0);
      rdc(8'h40, 32'h0);
      $display("test reset values done");
      run(32'h1234_5678, 1'b0, 1'b0);
      repeat (3) @(posedge clk);
      chk(n_pay, 0);
      rdc(`ISMP_ADDR_JOBS, 32'h0001_0000);
      $display("test mode off done");
      for (i = 0; i < 8; i = i + 1) begin
         pic = (i < 4) ? 2'h3 : 2'h1;
         wr(`ISMP_ADDR_CTRL, {29'h0, pic, 1'b1});
         // bit 26 set throughout; second field only on field pictures
         d = {i[3:0] ^ 4'h5, i >= 4, 1'b1, i[1:0], 24'h00a5c3};
         run(d, i[0], 1'b1);
         chk({mb_field_select, mb_second_field}, d[31:27]);
         chk({mb_pred_kind, mb_motion_reserved}, {ekind(d[25:24], pic), d[25:24] == 2'h0});
         @(posedge clk);
      end
      chk(n_pay, 128);
      $display("test motion kinds done");
      rdc(`ISMP_ADDR_JOBS, 32'h0001_0008);
      rdc(`ISMP_ADDR_LAST_DW0, d);
      wr(8'h40, 32'hffff_ffff);
      rdc(`ISMP_ADDR_CTRL, 32'h0000_0003);
      $display("test registers done");
      // restart the command while its header is still arriving
      p0 <= 32'h9e00_0001;
      slow <= 1'b1;
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      repeat (3) @(posedge clk);
      t = 0;
      while (!(in_valid && in_ready) && t < 8) begin
         @(posedge clk);
         t = t + 1;
      end
      if (t == 8) begin
         failures = failures + 1;
         report_and_stop;
      end
      run(32'h9e00_0001, 1'b1, 1'b1);
      d = {7'h00, 4'h9, 1'b1, 3'h3, 5'h00, 1'b0, 3'h4, 1'b1, 6'h00, 1'b1};
      rdc(`ISMP_ADDR_STATUS, d);
      wr(`ISMP_ADDR_STATUS, 32'h0000_0001);
      rdc(`ISMP_ADDR_STATUS, d & 32'hffff_fffe);
      rdc(`ISMP_ADDR_JOBS, 32'h0001_0009);
      $display("test truncated command done");
      report_and_stop;
   end
endmodule // ismp_payload_tb
